//--- hdl/rls_regs.sv
`timescale 1ns/1ps
module rls_regs
    import rls_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    input  wire logic [RLS_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [3:0]            avs_byteenable_in,
    input  wire logic [31:0]           avs_writedata_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    input  wire logic                  low_power_input_one_in,
    input  wire logic                  low_power_input_two_in,
    input  wire logic                  low_power_input_three_in,
    input  wire logic                  gpio_sleep_in,
    input  wire logic                  switch_current_limit_in,
    input  wire logic                  psm_reset_in,
    input  wire logic                  seq_slot_strobe_in,
    input  wire logic                  seq_shutdown_phase_in,
    input  wire logic [3:0]            seq_slot_in,
    input  wire logic                  seq_enter_active_in,
    input  wire logic                  seq_enter_off_in,
    input  wire logic                  linreg1_enabled_in,
    input  wire logic [2:0]            linreg_others_off_in,
    output logic                       conv6_sleep_out,
    output logic                       conv6_use_image_out,
    output logic                       conv6_force_standby_out,
    output logic                       conv6_force_linear_out,
    output logic                       conv6_disable_out,
    output logic      [6:0]            conv6_sleep_voltage_code_out,
    output logic                       switch_enable_out,
    output logic                       switch_bulk_detect_out,
    output logic                       system_shutdown_out,
    output logic                       linreg1_switch_mode_out,
    output logic      [4:0]            linreg1_voltage_code_out,
    output logic                       linreg1_discharge_out,
    output logic                       irq_out
);
    typedef struct packed {
        logic [15:0]          conv6_lp;
        logic [15:0]          sw_cfg;
        logic [15:0]          lr1_cfg;
        logic                 sleep_bit;
        logic [RLS_IRQ_W-1:0] irq_status;
        logic [RLS_IRQ_W-1:0] irq_mask;
        logic                 waitreq;
        logic [15:0]          rdata;
        logic                 sw_on;
        logic                 oc_prev;
        logic                 sleep_prev;
        logic                 alloff_prev;
        logic                 shutdown;
        logic                 c6_sleep;
        logic                 c6_image;
        logic                 c6_stby;
        logic                 c6_lin;
        logic                 c6_off;
        logic [6:0]           c6_vcode;
        logic                 sw_en;
        logic                 bulk;
        logic                 lr1_swmode;
        logic [4:0]           lr1_vcode;
        logic                 lr1_dis;
        logic                 irq;
    } rls_state_t;

    rls_state_t s_reg;
    rls_state_t s_next;

    logic [RLS_SYNC_W-1:0] pins_sync;
    logic                  lp1_s;
    logic                  lp2_s;
    logic                  lp3_s;
    logic                  gpio_s;
    logic                  oc_s;

    rls_sync #(
        .WIDTH (RLS_SYNC_W)
    ) u_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in ({switch_current_limit_in, gpio_sleep_in, low_power_input_three_in,
                    low_power_input_two_in, low_power_input_one_in}),
        .sync_out (pins_sync)
    );
    assign {oc_s, gpio_s, lp3_s, lp2_s, lp1_s} = pins_sync;

    logic [RLS_IDX_W-1:0] idx;
    logic                 req;
    logic                 done;
    logic [2:0]           behav;
    logic [1:0]           source;
    logic [6:0]           vimg;
    logic [1:0]           action;
    logic [3:0]           start_slot;
    logic [3:0]           stop_slot;
    logic                 sleep_now;
    logic                 sw_start;
    logic                 sw_stop;
    logic                 oc_rise;
    logic                 all_off;
    logic                 sw_en_now;

    assign idx        = avs_address_in[RLS_ADDR_W-1:2];
    assign req        = avs_read_in | avs_write_in;
    assign done       = req & ~s_reg.waitreq;
    assign behav      = s_reg.conv6_lp[RLS_C6_BEHAV_LSB +: 3];
    assign source     = s_reg.conv6_lp[RLS_C6_SOURCE_LSB +: 2];
    assign vimg       = s_reg.conv6_lp[RLS_C6_VCODE_LSB +: 7];
    assign action     = s_reg.sw_cfg[RLS_SW_ACTION_LSB +: 2];
    assign start_slot = s_reg.sw_cfg[RLS_SW_START_LSB +: 4];
    assign stop_slot  = s_reg.sw_cfg[RLS_SW_STOP_LSB +: 4];
    assign oc_rise    = oc_s & ~s_reg.oc_prev;
    assign all_off    = ~linreg1_enabled_in & (&linreg_others_off_in);

    function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [15:0] mask);
        logic [15:0] v;
        v = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
        return v & mask;
    endfunction

    always_comb begin
        logic [15:0]          rd_mux;
        logic [RLS_IRQ_W-1:0] events;
        logic [RLS_IRQ_W-1:0] clr;
        rd_mux = 16'h0000;
        events = '0;
        clr    = '0;
        s_next = s_reg;

        // Sleep source, GPIO sleep input overrides the select
        case (source)
            2'h0:    sleep_now = s_reg.sleep_bit;
            2'h1:    sleep_now = lp1_s;
            2'h2:    sleep_now = lp2_s;
            default: sleep_now = lp3_s;
        endcase
        sleep_now = sleep_now | gpio_s;

        // Read mux, unmapped indices read as zero
        case (idx)
            RLS_IDX_CONV6_LP: rd_mux = s_reg.conv6_lp;
            RLS_IDX_SWITCH:   rd_mux = s_reg.sw_cfg;
            RLS_IDX_LINREG1:  rd_mux = s_reg.lr1_cfg;
            RLS_IDX_CTRL:     rd_mux = {15'h0000, s_reg.sleep_bit};
            RLS_IDX_IRQ_STAT: rd_mux = {13'h0000, s_reg.irq_status};
            RLS_IDX_IRQ_MASK: rd_mux = {13'h0000, s_reg.irq_mask};
            default:          rd_mux = 16'h0000;
        endcase

        // One wait cycle per access; write lands on the completing edge
        s_next.waitreq = ~(req & s_reg.waitreq);
        if (avs_read_in && s_reg.waitreq) begin
            s_next.rdata = rd_mux;
        end
        if (done && avs_write_in) begin
            case (idx)
                RLS_IDX_CONV6_LP: s_next.conv6_lp = merge(s_reg.conv6_lp, avs_writedata_in,
                                                          avs_byteenable_in, RLS_C6_MASK);
                RLS_IDX_SWITCH:   s_next.sw_cfg = merge(s_reg.sw_cfg, avs_writedata_in,
                                                        avs_byteenable_in, RLS_SW_MASK);
                RLS_IDX_LINREG1:  s_next.lr1_cfg = merge(s_reg.lr1_cfg, avs_writedata_in,
                                                         avs_byteenable_in, RLS_LR_MASK);
                RLS_IDX_CTRL: begin
                    if (avs_byteenable_in[0]) begin
                        s_next.sleep_bit = avs_writedata_in[0];
                    end
                end
                RLS_IDX_IRQ_MASK: begin
                    if (avs_byteenable_in[0]) begin
                        s_next.irq_mask = avs_writedata_in[RLS_IRQ_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        // Power state machine wins over a software write in the same cycle
        if (psm_reset_in) begin
            s_next.conv6_lp = RLS_C6_DEFAULT;
            s_next.sw_cfg   = RLS_SW_DEFAULT;
            s_next.lr1_cfg  = RLS_LR_DEFAULT;
            s_next.shutdown = 1'b0;
        end

        // Converter sleep behaviour; reserved code falls into keep
        s_next.c6_sleep = sleep_now;
        s_next.c6_image = 1'b0;
        s_next.c6_stby  = 1'b0;
        s_next.c6_lin   = 1'b0;
        s_next.c6_off   = 1'b0;
        if (sleep_now) begin
            case (behav)
                RLS_BEH_IMAGE:    s_next.c6_image = 1'b1;
                RLS_BEH_STBY:     s_next.c6_stby = 1'b1;
                RLS_BEH_STBY_IMG: {s_next.c6_stby, s_next.c6_image} = 2'h3;
                RLS_BEH_LIN:      s_next.c6_lin = 1'b1;
                RLS_BEH_LIN_IMG:  {s_next.c6_lin, s_next.c6_image} = 2'h3;
                RLS_BEH_OFF:      s_next.c6_off = 1'b1;
                RLS_BEH_RSVD:     s_next.c6_image = 1'b0;
                default:          s_next.c6_image = 1'b0;
            endcase
        end
        // Codes past 3.4 V would overdrive the load, so clamp
        s_next.c6_vcode = (vimg > RLS_VCODE_MAX) ? RLS_VCODE_MAX : vimg;

        // Switch sequencing
        sw_start = (seq_slot_strobe_in && !seq_shutdown_phase_in && seq_slot_in == start_slot
                    && start_slot != RLS_SLOT_NONE && start_slot != RLS_SLOT_EDGE)
                   || (seq_enter_active_in && start_slot == RLS_SLOT_EDGE);
        sw_stop  = (seq_slot_strobe_in && seq_shutdown_phase_in && seq_slot_in == stop_slot
                    && stop_slot != RLS_SLOT_NONE && stop_slot != RLS_SLOT_EDGE)
                   || (seq_enter_off_in && (stop_slot == RLS_SLOT_NONE
                                            || stop_slot == RLS_SLOT_EDGE));
        if (sw_start) begin
            s_next.sw_on = 1'b1;
        end
        if (sw_stop) begin
            s_next.sw_on = 1'b0;
        end
        s_next.oc_prev = oc_s;
        if (oc_rise && s_reg.sw_on) begin
            events[RLS_IRQ_OC] = 1'b1;
            if (action == RLS_ACT_DISABLE) begin
                s_next.sw_on = 1'b0;
            end else if (action != RLS_ACT_IGNORE) begin
                s_next.shutdown = 1'b1;
            end
        end
        sw_en_now = s_reg.sw_on && (!sleep_now || s_reg.sw_cfg[RLS_SW_SLEEP_BIT]);
        s_next.sw_en = sw_en_now;
        s_next.bulk  = !sw_en_now && (sleep_now ? s_reg.sw_cfg[RLS_SW_SLBULK_BIT]
                                                : s_reg.sw_cfg[RLS_SW_ACBULK_BIT]);

        // Linear regulator one
        s_next.lr1_swmode = s_reg.lr1_cfg[RLS_LR_SWMODE_BIT];
        s_next.lr1_vcode  = s_reg.lr1_cfg[RLS_LR_SWMODE_BIT] ? 5'h00
                            : s_reg.lr1_cfg[RLS_LR_VCODE_LSB +: 5];
        s_next.lr1_dis    = !linreg1_enabled_in &&
                            (!s_reg.lr1_cfg[RLS_LR_FLOAT_BIT] || all_off);

        // Sticky events; a set in the clearing cycle survives
        s_next.sleep_prev = sleep_now;
        s_next.alloff_prev = all_off;
        events[RLS_IRQ_SLEEP]  = sleep_now & ~s_reg.sleep_prev;
        events[RLS_IRQ_ALLOFF] = all_off & ~s_reg.alloff_prev;
        if (done && avs_read_in && idx == RLS_IDX_IRQ_STAT) begin
            clr = '1;
        end
        s_next.irq_status = (s_reg.irq_status & ~clr) | events;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_reg           <= '0;
            s_reg.conv6_lp  <= RLS_C6_DEFAULT;
            s_reg.sw_cfg    <= RLS_SW_DEFAULT;
            s_reg.lr1_cfg   <= RLS_LR_DEFAULT;
            s_reg.waitreq   <= 1'b1;
            s_reg.bulk      <= 1'b1;
            s_reg.c6_vcode  <= RLS_C6_DEFAULT[6:0];
            s_reg.lr1_vcode <= RLS_LR_DEFAULT[4:0];
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata_out             = {16'h0000, s_reg.rdata};
    assign avs_waitrequest_out          = s_reg.waitreq;
    assign conv6_sleep_out              = s_reg.c6_sleep;
    assign conv6_use_image_out          = s_reg.c6_image;
    assign conv6_force_standby_out      = s_reg.c6_stby;
    assign conv6_force_linear_out       = s_reg.c6_lin;
    assign conv6_disable_out            = s_reg.c6_off;
    assign conv6_sleep_voltage_code_out = s_reg.c6_vcode;
    assign switch_enable_out            = s_reg.sw_en;
    assign switch_bulk_detect_out       = s_reg.bulk;
    assign system_shutdown_out          = s_reg.shutdown;
    assign linreg1_switch_mode_out      = s_reg.lr1_swmode;
    assign linreg1_voltage_code_out     = s_reg.lr1_vcode;
    assign linreg1_discharge_out        = s_reg.lr1_dis;
    assign irq_out                      = s_reg.irq;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    a_sleep_off_code: assert property (sleep_now && behav == RLS_BEH_OFF |=> conv6_disable_out)
        else $error("converter not disabled on off code");
    a_force_standby: assert property (sleep_now && behav[2:1] == 2'h1 |=>
        conv6_force_standby_out && !conv6_force_linear_out && conv6_use_image_out == $past(behav[0]))
        else $error("standby force wrong");
    a_source_select: assert property (source == 2'h1 && lp1_s |=> conv6_sleep_out)
        else $error("low-power input one not honoured");
    a_gpio_sleep: assert property (gpio_s |=> conv6_sleep_out)
        else $error("gpio sleep input ignored");
    a_vcode_clamp: assert property (##1 conv6_sleep_voltage_code_out <= RLS_VCODE_MAX)
        else $error("image code above limit");
    a_oc_shutdown: assert property (oc_rise && s_reg.sw_on && action[1] |=>
        system_shutdown_out throughout (1'b1 [*3]) or $past(psm_reset_in))
        else $error("overcurrent shutdown missing");
    a_never_start: assert property (start_slot == RLS_SLOT_NONE && !s_reg.sw_on |=>
        !s_reg.sw_on)
        else $error("switch started with slot none");
    a_stop_on_off: assert property (sw_stop |=> !s_reg.sw_on ##1 !switch_enable_out)
        else $error("switch not stopped");
    a_sleep_switch: assert property (sleep_now && !s_reg.sw_cfg[RLS_SW_SLEEP_BIT] |=>
        !switch_enable_out)
        else $error("switch on in sleep");
    a_bulk_detect: assert property (!sw_en_now |=> switch_bulk_detect_out ==
        $past(sleep_now ? s_reg.sw_cfg[RLS_SW_SLBULK_BIT] : s_reg.sw_cfg[RLS_SW_ACBULK_BIT]))
        else $error("bulk detect wrong");
    a_switch_mode: assert property (s_reg.lr1_cfg[RLS_LR_SWMODE_BIT] |=>
        linreg1_switch_mode_out && linreg1_voltage_code_out == 5'h00)
        else $error("voltage code not ignored");
    a_discharge_all: assert property (all_off |=> linreg1_discharge_out)
        else $error("all-off discharge missing");
    a_psm_default: assert property (psm_reset_in |=> s_reg.conv6_lp == RLS_C6_DEFAULT
        && s_reg.sw_cfg == RLS_SW_DEFAULT && s_reg.lr1_cfg == RLS_LR_DEFAULT)
        else $error("defaults not restored");
    a_reserved_keep: assert property (sleep_now && behav == RLS_BEH_RSVD |=>
        !conv6_force_standby_out && !conv6_force_linear_out && !conv6_disable_out && !conv6_use_image_out)
        else $error("reserved code changed output");
    a_bus_answer: assert property (req && s_reg.waitreq |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("waitrequest sequence wrong");

    c_oc_disable: cover property (oc_rise && s_reg.sw_on && action == RLS_ACT_DISABLE);
    c_sleep_image: cover property (sleep_now && behav == RLS_BEH_LIN_IMG);
    c_irq_clear: cover property (irq_out ##[1:20] !irq_out);
    c_slot_start: cover property (sw_start && seq_slot_strobe_in);
endmodule

//--- inc/rls_pkg.sv
package rls_pkg;

    localparam int unsigned RLS_ADDR_W      = 10;
    localparam int unsigned RLS_IDX_W       = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  RLS_IDX_CONV6_LP = 8'hC5;
    localparam logic [7:0]  RLS_IDX_SWITCH   = 8'hC7;
    localparam logic [7:0]  RLS_IDX_LINREG1  = 8'hC8;
    localparam logic [7:0]  RLS_IDX_CTRL     = 8'hE0;
    localparam logic [7:0]  RLS_IDX_IRQ_STAT = 8'hE1;
    localparam logic [7:0]  RLS_IDX_IRQ_MASK = 8'hE2;

    // conv6_low_power_cfg fields
    localparam int unsigned RLS_C6_BEHAV_LSB  = 12;
    localparam int unsigned RLS_C6_SOURCE_LSB = 8;
    localparam int unsigned RLS_C6_VCODE_LSB  = 0;
    localparam logic [15:0] RLS_C6_MASK       = 16'h737F;
    localparam logic [15:0] RLS_C6_DEFAULT    = 16'h0006;

    // current_limit_switch_cfg fields
    localparam int unsigned RLS_SW_ACTION_LSB = 14;
    localparam int unsigned RLS_SW_START_LSB  = 10;
    localparam int unsigned RLS_SW_STOP_LSB   = 6;
    localparam int unsigned RLS_SW_SLEEP_BIT  = 4;
    localparam int unsigned RLS_SW_SLBULK_BIT = 1;
    localparam int unsigned RLS_SW_ACBULK_BIT = 0;
    localparam logic [15:0] RLS_SW_MASK       = 16'hFFD3;
    localparam logic [15:0] RLS_SW_DEFAULT    = 16'h0003;

    // linear_reg1_cfg fields
    localparam int unsigned RLS_LR_SWMODE_BIT = 14;
    localparam int unsigned RLS_LR_FLOAT_BIT  = 10;
    localparam int unsigned RLS_LR_VCODE_LSB  = 0;
    localparam logic [15:0] RLS_LR_MASK       = 16'h441F;
    localparam logic [15:0] RLS_LR_DEFAULT    = 16'h001C;

    // Sleep behaviour codes
    localparam logic [2:0]  RLS_BEH_KEEP      = 3'h0;
    localparam logic [2:0]  RLS_BEH_IMAGE     = 3'h1;
    localparam logic [2:0]  RLS_BEH_STBY      = 3'h2;
    localparam logic [2:0]  RLS_BEH_STBY_IMG  = 3'h3;
    localparam logic [2:0]  RLS_BEH_LIN       = 3'h4;
    localparam logic [2:0]  RLS_BEH_LIN_IMG   = 3'h5;
    localparam logic [2:0]  RLS_BEH_RSVD      = 3'h6;
    localparam logic [2:0]  RLS_BEH_OFF       = 3'h7;

    localparam logic [6:0]  RLS_VCODE_MAX     = 7'h66;
    localparam logic [3:0]  RLS_SLOT_NONE     = 4'h0;
    localparam logic [3:0]  RLS_SLOT_EDGE     = 4'hF;
    localparam logic [1:0]  RLS_ACT_IGNORE    = 2'h0;
    localparam logic [1:0]  RLS_ACT_DISABLE   = 2'h1;

    // Interrupt status and mask layout
    localparam int unsigned RLS_IRQ_W         = 3;
    localparam int unsigned RLS_IRQ_OC        = 0;
    localparam int unsigned RLS_IRQ_SLEEP     = 1;
    localparam int unsigned RLS_IRQ_ALLOFF    = 2;

    localparam int unsigned RLS_SYNC_W        = 5;

endpackage

//--- hdl/rls_sync.sv
`timescale 1ns/1ps
module rls_sync
    import rls_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // One two-stage chain per pin; first stage feeds only the second
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock_in) begin
            if (rst_in) begin
                meta_reg[i] <= 1'b0;
                sync_reg[i] <= 1'b0;
            end else begin
                meta_reg[i] <= async_in[i];
                sync_reg[i] <= meta_reg[i];
            end
        end
    end

    assign sync_out = sync_reg;
endmodule

//--- verification/rls_host.sv
`timescale 1ns/1ps
module rls_host (
    input  wire logic        clock_in,
    input  wire logic        avs_waitrequest_in,
    output logic      [9:0]  avs_address_out,
    output logic             avs_read_out,
    output logic             avs_write_out,
    output logic      [31:0] avs_writedata_out
);
    initial begin
        {avs_address_out, avs_read_out, avs_write_out, avs_writedata_out} <= '0;
    end
    // Request is held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        @(posedge clock_in);
        avs_address_out   <= {idx, 2'h0};
        avs_read_out      <= !wr;
        avs_write_out     <= wr;
        avs_writedata_out <= {16'h0000, d};
        do @(posedge clock_in); while (avs_waitrequest_in !== 1'b0);
        avs_read_out  <= 1'b0;
        avs_write_out <= 1'b0;
    endtask
endmodule

//--- verification/regulator_lowpower_switch_regs_test.sv
`timescale 1ns/1ps
module regulator_lowpower_switch_regs_test;
    import rls_pkg::*;
    logic clock_in = 0, rst_in = 1, gpio_sleep_in = 0, switch_current_limit_in = 0, psm_reset_in = 0;
    logic seq_slot_strobe_in = 0, linreg1_enabled_in = 1, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic seq_shutdown_phase_in = 0, seq_enter_active_in = 0, seq_enter_off_in = 0;
    logic switch_bulk_detect_out, system_shutdown_out, linreg1_switch_mode_out;
    logic [2:0] lp = 0, linreg_others_off_in = 0;
    logic [3:0] seq_slot_in = 0, slot;
    logic [9:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    logic conv6_sleep_out, conv6_use_image_out, conv6_force_standby_out, conv6_force_linear_out;
    logic conv6_disable_out, switch_enable_out, linreg1_discharge_out, irq_out;
    logic [6:0] conv6_sleep_voltage_code_out;
    logic [4:0] linreg1_voltage_code_out;
    logic [15:0] exp_q[$];
    int num_errors = 0, n_checks = 0, seed = 44;
    always #4 clock_in = ~clock_in;
    rls_host u_host (.clock_in, .avs_waitrequest_in(avs_waitrequest_out), .avs_address_out(avs_address_in),
        .avs_read_out(avs_read_in), .avs_write_out(avs_write_in), .avs_writedata_out(avs_writedata_in));
    rls_regs u_dut (.clock_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_byteenable_in(4'h3),
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .low_power_input_one_in(lp[0]),
        .low_power_input_two_in(lp[1]), .low_power_input_three_in(lp[2]), .gpio_sleep_in,
        .switch_current_limit_in, .psm_reset_in, .seq_slot_strobe_in, .seq_shutdown_phase_in,
        .seq_slot_in, .seq_enter_active_in, .seq_enter_off_in, .linreg1_enabled_in,
        .linreg_others_off_in, .conv6_sleep_out, .conv6_use_image_out, .conv6_force_standby_out,
        .conv6_force_linear_out, .conv6_disable_out, .conv6_sleep_voltage_code_out, .switch_enable_out,
        .switch_bulk_detect_out, .system_shutdown_out, .linreg1_switch_mode_out,
        .linreg1_voltage_code_out, .linreg1_discharge_out, .irq_out);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] i, input logic [15:0] d);
        u_host.xfer(1'b1, i, d);
    endtask
    task automatic rd(input logic [7:0] i, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, i, 16'h0000);
    endtask
    task automatic settle;
        repeat (5) @(posedge clock_in);
    endtask
    // Read data is judged only at the completing edge
    always @(posedge clock_in)
        if (avs_read_in && avs_waitrequest_out === 1'b0 && exp_q.size() > 0) chk(avs_readdata_out, exp_q.pop_front());
    initial begin
        #400000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rd(RLS_IDX_CONV6_LP, RLS_C6_DEFAULT);
        rd(RLS_IDX_SWITCH, RLS_SW_DEFAULT);
        rd(RLS_IDX_LINREG1, RLS_LR_DEFAULT);
        rd(8'h10, 16'h0000);
        wr(RLS_IDX_IRQ_MASK, 16'h0002);
        wr(RLS_IDX_CTRL, 16'h0001);
        settle;
        chk(irq_out, 1);
        rd(RLS_IDX_IRQ_STAT, 16'h0002);
        settle;
        chk(irq_out, 0);
        for (int b = 0; b < 8; b++) begin
            wr(RLS_IDX_CONV6_LP, 16'(b << 12));
            settle;
            chk({conv6_disable_out, conv6_force_linear_out, conv6_force_standby_out, conv6_use_image_out},
                {b == 7, b == 4 || b == 5, b == 2 || b == 3, b == 1 || b == 3 || b == 5});
        end
        wr(RLS_IDX_CONV6_LP, 16'h127F);
        lp <= 3'h2;
        settle;
        chk({conv6_sleep_out, conv6_sleep_voltage_code_out}, {1'b1, RLS_VCODE_MAX});
        lp <= 3'h0;
        settle;
        chk(conv6_sleep_out, 0);
        gpio_sleep_in <= 1'b1;
        settle;
        chk(conv6_sleep_out, 1);
        psm_reset_in <= 1'b1;
        @(posedge clock_in);
        psm_reset_in <= 1'b0;
        rd(RLS_IDX_CONV6_LP, RLS_C6_DEFAULT);
        slot = 4'(($random(seed) & 7) + 1);
        wr(RLS_IDX_SWITCH, {2'h1, slot, 10'h013});
        seq_slot_in <= slot;
        seq_slot_strobe_in <= 1'b1;
        @(posedge clock_in);
        seq_slot_strobe_in <= 1'b0;
        settle;
        chk(switch_enable_out, 1);
        switch_current_limit_in <= 1'b1;
        settle;
        chk(switch_enable_out, 0);
        switch_current_limit_in <= 1'b0;
        wr(RLS_IDX_SWITCH, {2'h2, 4'hF, slot, 6'h13});
        seq_enter_active_in <= 1'b1;
        @(posedge clock_in);
        seq_enter_active_in <= 1'b0;
        seq_enter_off_in <= 1'b1;
        @(posedge clock_in);
        seq_enter_off_in <= 1'b0;
        settle;
        chk({switch_enable_out, switch_bulk_detect_out}, 2'h2);
        switch_current_limit_in <= 1'b1;
        settle;
        chk({switch_enable_out, system_shutdown_out}, 2'h3);
        seq_shutdown_phase_in <= 1'b1;
        seq_slot_strobe_in <= 1'b1;
        @(posedge clock_in);
        seq_slot_strobe_in <= 1'b0;
        seq_shutdown_phase_in <= 1'b0;
        settle;
        chk({switch_enable_out, switch_bulk_detect_out, system_shutdown_out}, 3'h3);
        psm_reset_in <= 1'b1;
        @(posedge clock_in);
        psm_reset_in <= 1'b0;
        settle;
        chk(system_shutdown_out, 0);
        wr(RLS_IDX_LINREG1, 16'h0413);
        settle;
        chk({linreg1_switch_mode_out, linreg1_voltage_code_out, linreg1_discharge_out}, 7'h26);
        wr(RLS_IDX_LINREG1, 16'h441C);
        linreg1_enabled_in <= 1'b0;
        settle;
        chk({linreg1_switch_mode_out, linreg1_voltage_code_out, linreg1_discharge_out}, 7'h40);
        linreg_others_off_in <= 3'h7;
        settle;
        chk(linreg1_discharge_out, 1);
        tally_and_finish;
    end
endmodule
